/* bic_channel.sv */
// bic_channel: byte multiplexer channel with polled control units,
// per-subchannel context words and an output-byte fifo.
// assumes control units hold data and device address stable while
// their request is high, and drop the request after the service ack.
`timescale 1ns/1ps

// ************************************************
// output byte fifo
// ************************************************
module bic_fifo #(
   parameter int W = 16,
   parameter int DEPTH = 16
) (
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic in_valid_in,
   output logic in_ready_out,
   input wire logic [W-1:0] in_data_in,
   output logic out_valid_out,
   input wire logic out_ready_in,
   output logic [W-1:0] out_data_out
);
   localparam int PW = $clog2(DEPTH);
   localparam logic [PW:0] FULL = DEPTH[PW:0];
   typedef struct packed {
      logic [PW-1:0] rd;
      logic [PW-1:0] wr;
      logic [PW:0] cnt;
      logic ov;
      logic [W-1:0] od;
   } bic_fifo_s;
   bic_fifo_s f_r;
   bic_fifo_s f_nxt;
   logic [W-1:0] mem [DEPTH];
   logic push;
   logic pull;

   assign in_ready_out = (f_r.cnt != FULL);
   assign out_valid_out = f_r.ov;
   assign out_data_out = f_r.od;

   always_comb begin
      f_nxt = f_r;
      push = in_valid_in && (f_r.cnt != FULL);
      pull = (!f_r.ov || out_ready_in) && (f_r.cnt != '0);
      if (f_r.ov && out_ready_in) begin
         f_nxt.ov = 1'b0;
      end
      if (pull) begin
         f_nxt.od = mem[f_r.rd];
         f_nxt.ov = 1'b1;
         f_nxt.rd = f_r.rd + 1'b1;
      end
      if (push) begin
         f_nxt.wr = f_r.wr + 1'b1;
      end
      f_nxt.cnt = f_r.cnt + {{PW{1'b0}}, push} - {{PW{1'b0}}, pull};
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         f_r <= '0;
      end else begin
         f_r <= f_nxt;
      end
   end

   // storage array has no reset: only written words are ever read
   always_ff @(posedge clk_in) begin
      if (push) begin
         mem[f_r.wr] <= in_data_in;
      end
   end
endmodule : bic_fifo

// ************************************************
// channel
// ************************************************
// What this block does
// - byte mode: subchannels share channel logic, one byte per service
// - a started non-burst device never holds the channel between its bytes
// - burst subchannel keeps the channel until its record completes
// - each subchannel owns a saved context word for resuming
// - context word holds remaining count, next address, protect key
// - idle channel with request polls units in attachment order
// - first polled ready high-priority unit is served via its subchannel
// - load context, move one byte, update, write context back
// - after write back of a non-burst or finished operation the channel is free for any request
// - eight control units, 256 device addresses
// - 31 subchannels, each with its own context word
// - one operation per subchannel; a busy subchannel refuses a start
// - input bytes stored only where block key matches operation key, or the operation key is 0
module bic_channel (
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic [bic_pkg::NCU-1:0] cu_req_in,
   input wire logic [bic_pkg::NCU-1:0] cu_hipri_in,
   input wire logic [bic_pkg::NCU-1:0][bic_pkg::DEVW-1:0] cu_dev_in,
   input wire logic [bic_pkg::NCU-1:0][7:0] cu_data_in,
   output logic [bic_pkg::NCU-1:0] poll_out,
   output logic [bic_pkg::NCU-1:0] svc_ack_out,
   input wire logic start_valid_in,
   input wire bic_pkg::bic_start_s start_in,
   output logic start_ready_out,
   output logic start_resp_valid_out,
   output logic start_resp_ok_out,
   output logic mem_req_out,
   output logic mem_we_out,
   output logic [bic_pkg::ADRW-1:0] mem_addr_out,
   output logic [7:0] mem_wdata_out,
   output logic [bic_pkg::KEYW-1:0] mem_key_out,
   input wire logic mem_ack_in,
   input wire logic [7:0] mem_rdata_in,
   input wire logic [bic_pkg::KEYW-1:0] mem_block_key_in,
   output logic out_valid_out,
   input wire logic out_ready_in,
   output logic [bic_pkg::FIFO_W-1:0] out_data_out,
   output logic done_valid_out,
   output bic_pkg::bic_done_s done_out
);
   typedef struct packed {
      bic_pkg::bic_state_e state;
      logic [bic_pkg::NCU-1:0] req_s1, req_s2, req_s3, req_f;
      logic [bic_pkg::NCU-1:0] hip_s1, hip_s2, hip_s3, hip_f;
      logic [bic_pkg::NCU-1:0] acked;
      logic [bic_pkg::CUW-1:0] idx;
      logic lo_found;
      logic [bic_pkg::CUW-1:0] lo_idx;
      logic [bic_pkg::CUW-1:0] sel;
      logic [bic_pkg::SCW-1:0] sc;
      bic_pkg::bic_ctx_s work;
      logic err;
      bic_pkg::bic_ctx_s [bic_pkg::NSC-1:0] ctx;
      logic [bic_pkg::NCU-1:0] poll;
      logic [bic_pkg::NCU-1:0] ack;
      logic start_ready;
      logic resp_valid;
      logic resp_ok;
      logic mem_req;
      logic mem_we;
      logic [bic_pkg::ADRW-1:0] mem_addr;
      logic [7:0] mem_wdata;
      logic [bic_pkg::KEYW-1:0] mem_key;
      logic push;
      logic [bic_pkg::FIFO_W-1:0] push_data;
      logic done_valid;
      bic_pkg::bic_done_s done;
   } bic_st_s;

   bic_st_s st_r;
   bic_st_s st_nxt;
   logic fifo_ready;
   logic [bic_pkg::NCU-1:0] want;
   logic hit;
   logic [bic_pkg::SCW-1:0] hit_sc;
   logic lo_f;
   logic [bic_pkg::CUW-1:0] lo_i;
   logic key_bad;

   bic_fifo #(
      .W(bic_pkg::FIFO_W),
      .DEPTH(bic_pkg::FIFO_DEPTH)
   ) u_fifo (
      .clk_in(clk_in),
      .rst_n_in(rst_n_in),
      .in_valid_in(st_r.push),
      .in_ready_out(fifo_ready),
      .in_data_in(st_r.push_data),
      .out_valid_out(out_valid_out),
      .out_ready_in(out_ready_in),
      .out_data_out(out_data_out)
   );

   always_comb begin
      st_nxt = st_r;
      st_nxt.ack = '0;
      st_nxt.resp_valid = 1'b0;
      st_nxt.push = 1'b0;
      st_nxt.done_valid = 1'b0;
      hit = 1'b0;
      hit_sc = '0;
      lo_f = st_r.lo_found;
      lo_i = st_r.lo_idx;
      // three-stage sync; a level counts once stages two and three agree
      st_nxt.req_s1 = cu_req_in;
      st_nxt.req_s2 = st_r.req_s1;
      st_nxt.req_s3 = st_r.req_s2;
      st_nxt.hip_s1 = cu_hipri_in;
      st_nxt.hip_s2 = st_r.hip_s1;
      st_nxt.hip_s3 = st_r.hip_s2;
      for (int i = 0; i < bic_pkg::NCU; i++) begin
         if (st_r.req_s2[i] == st_r.req_s3[i]) begin
            st_nxt.req_f[i] = st_r.req_s3[i];
         end
         if (st_r.hip_s2[i] == st_r.hip_s3[i]) begin
            st_nxt.hip_f[i] = st_r.hip_s3[i];
         end
         // a served unit is ignored until its request is seen low
         if (!st_r.req_f[i]) begin
            st_nxt.acked[i] = 1'b0;
         end
      end
      want = st_r.req_f & ~st_r.acked;
      for (int j = bic_pkg::NSC - 1; j >= 0; j--) begin
         if (st_r.ctx[j].active &&
             st_r.ctx[j].dev == cu_dev_in[st_r.sel]) begin
            hit = 1'b1;
            hit_sc = j[bic_pkg::SCW-1:0];
         end
      end
      key_bad = st_r.work.dir_in && st_r.work.key != bic_pkg::KEY_MASTER &&
                st_r.work.key != mem_block_key_in;
      case (st_r.state)
         bic_pkg::ST_IDLE: begin
            if (start_valid_in && st_r.start_ready) begin
               st_nxt.resp_valid = 1'b1;
               st_nxt.resp_ok = start_in.sc < bic_pkg::SCW'(bic_pkg::NSC) &&
                                !st_r.ctx[start_in.sc].active &&
                                start_in.ctx.count != '0;
               if (st_nxt.resp_ok) begin
                  st_nxt.ctx[start_in.sc] = start_in.ctx;
                  st_nxt.ctx[start_in.sc].active = 1'b1;
               end
            end else if (want != '0) begin
               st_nxt.state = bic_pkg::ST_POLL;
               st_nxt.idx = '0;
               st_nxt.lo_found = 1'b0;
               st_nxt.poll = bic_pkg::POLL_FIRST;
            end
         end
         bic_pkg::ST_POLL: begin
            if (want[st_r.idx] && st_r.hip_f[st_r.idx]) begin
               st_nxt.sel = st_r.idx;
               st_nxt.state = bic_pkg::ST_FIND;
            end else begin
               if (want[st_r.idx] && !lo_f) begin
                  lo_f = 1'b1;
                  lo_i = st_r.idx;
               end
               st_nxt.lo_found = lo_f;
               st_nxt.lo_idx = lo_i;
               if (st_r.idx == bic_pkg::CU_LAST) begin
                  if (lo_f) begin
                     st_nxt.sel = lo_i;
                     st_nxt.poll = bic_pkg::POLL_FIRST << lo_i;
                     st_nxt.state = bic_pkg::ST_FIND;
                  end else begin
                     st_nxt.poll = '0;
                     st_nxt.state = bic_pkg::ST_IDLE;
                  end
               end else begin
                  st_nxt.idx = st_r.idx + 1'b1;
                  st_nxt.poll = bic_pkg::POLL_FIRST << (st_r.idx + 1'b1);
               end
            end
         end
         bic_pkg::ST_FIND: begin
            if (hit) begin
               st_nxt.sc = hit_sc;
               st_nxt.state = bic_pkg::ST_LOAD;
            end else begin
               // no operation for this device: take the byte and drop it
               st_nxt.ack[st_r.sel] = 1'b1;
               st_nxt.acked[st_r.sel] = 1'b1;
               st_nxt.poll = '0;
               st_nxt.state = bic_pkg::ST_IDLE;
            end
         end
         bic_pkg::ST_LOAD: begin
            st_nxt.work = st_r.ctx[st_r.sc];
            st_nxt.err = 1'b0;
            st_nxt.mem_addr = st_r.ctx[st_r.sc].addr;
            st_nxt.mem_key = st_r.ctx[st_r.sc].key;
            st_nxt.mem_we = st_r.ctx[st_r.sc].dir_in;
            st_nxt.mem_wdata = cu_data_in[st_r.sel];
            st_nxt.state = bic_pkg::ST_CHK;
         end
         bic_pkg::ST_CHK: begin
            if (key_bad) begin
               st_nxt.work.active = 1'b0;
               st_nxt.err = 1'b1;
               st_nxt.ack[st_r.sel] = 1'b1;
               st_nxt.acked[st_r.sel] = 1'b1;
               st_nxt.state = bic_pkg::ST_WB;
            end else if (st_r.work.dir_in || fifo_ready) begin
               // output waits for fifo room so a stalled drain backs up here
               st_nxt.mem_req = 1'b1;
               st_nxt.state = bic_pkg::ST_XFER;
            end
         end
         bic_pkg::ST_XFER: begin
            if (mem_ack_in) begin
               st_nxt.mem_req = 1'b0;
               st_nxt.push = !st_r.work.dir_in;
               st_nxt.push_data = {st_r.work.dev, mem_rdata_in};
               st_nxt.work.count = st_r.work.count - bic_pkg::CNT_ONE;
               st_nxt.work.addr = st_r.work.addr + bic_pkg::ADR_ONE;
               st_nxt.work.active = st_r.work.count != bic_pkg::CNT_ONE;
               st_nxt.ack[st_r.sel] = 1'b1;
               st_nxt.acked[st_r.sel] = 1'b1;
               st_nxt.state = bic_pkg::ST_WB;
            end
         end
         bic_pkg::ST_WB: begin
            st_nxt.ctx[st_r.sc] = st_r.work;
            if (!st_r.work.active) begin
               st_nxt.done_valid = 1'b1;
               st_nxt.done.sc = st_r.sc;
               st_nxt.done.err = st_r.err;
            end
            if (st_r.work.burst && st_r.work.active) begin
               st_nxt.state = bic_pkg::ST_BURST;
            end else begin
               st_nxt.poll = '0;
               st_nxt.state = bic_pkg::ST_IDLE;
            end
         end
         bic_pkg::ST_BURST: begin
            if (st_r.req_f[st_r.sel] && !st_r.acked[st_r.sel]) begin
               st_nxt.state = bic_pkg::ST_LOAD;
            end
         end
         default: begin
            st_nxt.state = bic_pkg::ST_IDLE;
            st_nxt.poll = '0;
         end
      endcase
      st_nxt.start_ready = st_nxt.state == bic_pkg::ST_IDLE &&
                           !st_nxt.resp_valid;
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign poll_out = st_r.poll;
   assign svc_ack_out = st_r.ack;
   assign start_ready_out = st_r.start_ready;
   assign start_resp_valid_out = st_r.resp_valid;
   assign start_resp_ok_out = st_r.resp_ok;
   assign mem_req_out = st_r.mem_req;
   assign mem_we_out = st_r.mem_we;
   assign mem_addr_out = st_r.mem_addr;
   assign mem_wdata_out = st_r.mem_wdata;
   assign mem_key_out = st_r.mem_key;
   assign done_valid_out = st_r.done_valid;
   assign done_out = st_r.done;
endmodule : bic_channel

/* bic_pkg.sv */
// bic_pkg: constants, states and carriers of the byte interleaved channel.
// assumes one 100 MHz clock shared by storage, starter and fifo drain.
package bic_pkg;
   // ************************************************
   // sizes
   // ************************************************
   localparam int NCU = 8;
   localparam int NSC = 31;
   localparam int CUW = 3;
   localparam int SCW = 5;
   localparam int DEVW = 8;
   localparam int CNTW = 16;
   localparam int ADRW = 24;
   localparam int KEYW = 4;
   localparam int FIFO_DEPTH = 16;
   localparam int FIFO_W = DEVW + 8;
   localparam logic [KEYW-1:0] KEY_MASTER = 4'h0;
   localparam logic [CNTW-1:0] CNT_ONE = 16'h0001;
   localparam logic [ADRW-1:0] ADR_ONE = 24'h000001;
   localparam logic [CUW-1:0] CU_LAST = 3'h7;
   localparam logic [NCU-1:0] POLL_FIRST = 8'h01;

   // ************************************************
   // types
   // ************************************************
   typedef enum logic [2:0] {
      ST_IDLE, ST_POLL, ST_FIND, ST_LOAD, ST_CHK, ST_XFER, ST_WB, ST_BURST
   } bic_state_e;

   typedef struct packed {
      logic active;
      logic burst;
      logic dir_in;
      logic [DEVW-1:0] dev;
      logic [CNTW-1:0] count;
      logic [ADRW-1:0] addr;
      logic [KEYW-1:0] key;
   } bic_ctx_s;

   typedef struct packed {
      logic [SCW-1:0] sc;
      bic_ctx_s ctx;
   } bic_start_s;

   typedef struct packed {
      logic [SCW-1:0] sc;
      logic err;
   } bic_done_s;

   localparam bic_ctx_s CTX_RESET = '0;
endpackage : bic_pkg

/* bic_channel_props.sv */
// bic_channel_props: port checker bound into bic_channel.
// assumes one clock domain and the async active-low reset.
`timescale 1ns/1ps
module bic_channel_props (
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic [7:0] cu_req_in,
   input wire logic [7:0] poll_out,
   input wire logic [7:0] svc_ack_out,
   input wire logic start_valid_in,
   input wire logic start_ready_out,
   input wire logic start_resp_valid_out,
   input wire logic mem_req_out,
   input wire logic mem_we_out,
   input wire logic [23:0] mem_addr_out,
   input wire logic [3:0] mem_key_out,
   input wire logic mem_ack_in,
   input wire logic [3:0] mem_block_key_in,
   input wire logic out_valid_out,
   input wire logic out_ready_in
);
   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (!rst_n_in);
   // *****
   // properties
   // *****
   property p_hot; $onehot0(poll_out); endproperty
   a_hot: assert property (p_hot) else $error("poll not one-hot");
   property p_first; $rose(|poll_out) |-> poll_out == 8'h01; endproperty
   a_first: assert property (p_first) else $error("poll start");
   property p_ack; $onehot0(svc_ack_out); endproperty
   a_ack: assert property (p_ack) else $error("ack not one-hot");
   property p_pulse; |svc_ack_out |=> !(|svc_ack_out); endproperty
   a_pulse: assert property (p_pulse) else $error("ack held");
   property p_hold;
      mem_req_out && !mem_ack_in |=> mem_req_out && $stable(mem_addr_out);
   endproperty
   a_hold: assert property (p_hold) else $error("storage req");
   property p_done;
      mem_req_out && mem_ack_in |=> !mem_req_out && (|svc_ack_out);
   endproperty
   a_done: assert property (p_done) else $error("no ack");
   // key 0 may store into any block
   property p_key;
      mem_req_out && mem_we_out |->
         mem_key_out == 4'h0 || mem_key_out == mem_block_key_in;
   endproperty
   a_key: assert property (p_key) else $error("key");
   property p_start;
      start_valid_in && start_ready_out |=>
         start_resp_valid_out && !start_ready_out;
   endproperty
   a_start: assert property (p_start) else $error("start resp");
   sequence s_quiet;
      (cu_req_in == 8'h00 && !start_valid_in) [*8];
   endsequence
   property p_idle; s_quiet |-> !mem_req_out && poll_out == 8'h00; endproperty
   a_idle: assert property (p_idle) else $error("not idle");
   c_wr: cover property (mem_req_out && mem_ack_in && mem_we_out);
   c_full: cover property ((out_valid_out && !out_ready_in) [*8]);
   c_poll: cover property ($rose(|poll_out));
endmodule : bic_channel_props

bind bic_channel bic_channel_props bic_channel_props_i (
   .clk_in, .rst_n_in, .cu_req_in, .poll_out, .svc_ack_out,
   .start_valid_in, .start_ready_out, .start_resp_valid_out,
   .mem_req_out, .mem_we_out, .mem_addr_out, .mem_key_out,
   .mem_ack_in, .mem_block_key_in, .out_valid_out, .out_ready_in
);

/* bic_cu_model.sv */
// bic_cu_model: eight control units offering queued bytes.
// assumes the bench fills queues by send and sets gap and wait_c.
`timescale 1ns/1ps
module bic_cu_model (
   input wire logic clk_in,
   input wire logic [7:0] svc_ack_in,
   output logic [7:0] req_out,
   output logic [7:0][7:0] dev_out,
   output logic [7:0][7:0] data_out
);
   logic [15:0] q [8][$];
   int gap [8] = '{default: 0};
   int wait_c [8] = '{default: 0};
   initial begin
      req_out = 8'h00;
      dev_out = '0;
      data_out = '0;
   end
   task send(input int u, input logic [15:0] dv);
      q[u].push_back(dv);
   endtask : send
   // *****
   // units
   // *****
   // released lines flip so stale bytes are never mistaken for new
   always @(negedge clk_in) begin
      for (int u = 0; u < 8; u++) begin
         if (req_out[u] && svc_ack_in[u]) begin
            req_out[u] <= 1'b0;
            dev_out[u] <= ~dev_out[u];
            data_out[u] <= ~data_out[u];
            void'(q[u].pop_front());
            // low long enough for the channel's three-stage request filter
            wait_c[u] <= gap[u] + 3;
         end else if (!req_out[u] && wait_c[u] > 0) begin
            wait_c[u] <= wait_c[u] - 1;
         end else if (!req_out[u] && q[u].size() > 0) begin
            req_out[u] <= 1'b1;
            dev_out[u] <= q[u][0][15:8];
            data_out[u] <= q[u][0][7:0];
         end
      end
   end
endmodule : bic_cu_model

/* test_bic_channel.sv */
// test_bic_channel: self-checking bench of bic_channel.
// assumes the unit model, storage and sink below, one 100 MHz clock.
`timescale 1ns/1ps
module test_bic_channel;
   logic clk_in = 1'b0;
   logic rst_n_in = 1'b0;
   logic [7:0] cu_hipri_in = 8'hC0;
   logic [7:0] cu_req, svc_ack, poll_out;
   logic [7:0][7:0] cu_dev, cu_data;
   logic start_valid_in = 1'b0;
   bic_pkg::bic_start_s start_in = '0;
   logic start_ready_out, start_resp_valid_out, start_resp_ok_out;
   logic mem_req_out, mem_we_out, mem_ack_in = 1'b0;
   logic [23:0] mem_addr_out;
   logic [7:0] mem_wdata_out, mem_rdata_in;
   logic [3:0] mem_key_out, mem_block_key_in;
   logic out_valid_out, out_ready_in = 1'b0, done_valid_out, stall = 1'b0;
   logic [15:0] out_data_out;
   bic_pkg::bic_done_s done_out;
   logic [39:0] exp_q [4][$];
   int bad_count = 0;
   int n_compared = 0;
   logic [31:0] rs = 32'h0000BF4E;
   wire wr_seen = mem_req_out && mem_ack_in && mem_we_out;
   function automatic logic [31:0] xs(input logic [31:0] v);
      logic [31:0] x;
      x = v ^ (v << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction : xs
   // *****
   // storage, sink and design
   // *****
   // block key taken from address bits 14:11
   assign mem_rdata_in = mem_addr_out[7:0] ^ 8'hA5;
   assign mem_block_key_in = mem_addr_out[14:11];
   initial forever #5 clk_in = ~clk_in;
   always @(negedge clk_in) begin
      rs <= xs(rs);
      mem_ack_in <= mem_req_out && !mem_ack_in && rs[0];
      out_ready_in <= !stall && (rs[1] || rs[2]);
   end
   bic_channel bic_channel_i (
      .clk_in, .rst_n_in, .cu_req_in(cu_req), .cu_hipri_in,
      .cu_dev_in(cu_dev), .cu_data_in(cu_data), .poll_out,
      .svc_ack_out(svc_ack), .start_valid_in, .start_in, .start_ready_out,
      .start_resp_valid_out, .start_resp_ok_out, .mem_req_out, .mem_we_out,
      .mem_addr_out, .mem_wdata_out, .mem_key_out, .mem_ack_in,
      .mem_rdata_in, .mem_block_key_in, .out_valid_out, .out_ready_in,
      .out_data_out, .done_valid_out, .done_out
   );
   bic_cu_model bic_cu_model_i (
      .clk_in, .svc_ack_in(svc_ack), .req_out(cu_req), .dev_out(cu_dev),
      .data_out(cu_data)
   );
   // *****
   // checking
   // *****
   task fail(input string m);
      bad_count++;
      $display("FAIL %0t %s", $time, m);
   endtask : fail
   task cmp_core(input int k, input logic [39:0] g);
      n_compared++;
      if (exp_q[k].size() == 0) fail($sformatf("kind %0d extra %h", k, g));
      else if (g !== exp_q[k].pop_front()) begin
         fail($sformatf("kind %0d %h", k, g));
      end
   endtask : cmp_core
   task cmp_out(input logic [15:0] g);
      cmp_core(0, {24'h0, g});
   endtask : cmp_out
   task cmp_wr(input logic [31:0] g);
      cmp_core(1, {8'h0, g});
   endtask : cmp_wr
   task cmp_resp(input logic g);
      cmp_core(2, {39'h0, g});
   endtask : cmp_resp
   task cmp_done(input logic [5:0] g);
      cmp_core(3, {34'h0, g});
   endtask : cmp_done
   always @(posedge clk_in) if (rst_n_in) begin
      if (out_valid_out && out_ready_in) cmp_out(out_data_out);
      if (wr_seen) cmp_wr({mem_addr_out, mem_wdata_out});
      if (start_resp_valid_out) cmp_resp(start_resp_ok_out);
      if (done_valid_out) cmp_done(done_out);
   end
   task final_report;
      foreach (exp_q[k]) if (exp_q[k].size() != 0) fail("result missing");
      if (bad_count == 0 && n_compared > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : final_report
   // *****
   // drivers
   // *****
   task automatic start(input logic [4:0] sc, input logic [2:0] md,
         input logic [7:0] dv, input logic [15:0] n, input logic [23:0] a,
         input logic [3:0] k, input logic ok);
      int t;
      exp_q[2].push_back({39'h0, ok});
      @(negedge clk_in);
      start_in <= {sc, md, dv, n, a, k};
      start_valid_in <= 1'b1;
      for (t = 0; t < 80; t++) begin
         @(posedge clk_in);
         if (start_ready_out === 1'b1) break;
      end
      @(negedge clk_in);
      start_valid_in <= 1'b0;
      if (t == 80) begin
         fail("start not taken");
         final_report();
      end
   endtask : start
   task automatic op(input int u, input logic [4:0] sc,
         input logic [2:0] md, input logic [7:0] dv, input int n,
         input logic [23:0] a, input logic [3:0] k, input logic err);
      logic [7:0] d;
      start(sc, md, dv, n[15:0], a, k, 1'b1);
      for (int i = 0; i < n; i++) begin
         d = rs[7:0] ^ i[7:0];
         bic_cu_model_i.send(u, {dv, d});
         if (md[0] && !err) exp_q[1].push_back({8'h00, a + i[23:0], d});
      end
      exp_q[3].push_back({34'h0, sc, err});
   endtask : op
   task exp_rd(input logic [7:0] dv, input logic [23:0] a);
      exp_q[0].push_back({24'h0, dv, a[7:0] ^ 8'hA5});
   endtask : exp_rd
   task drain;
      int t;
      for (t = 0; t < 3000; t++) begin
         @(posedge clk_in);
         if (exp_q[0].size() + exp_q[1].size() + exp_q[3].size() == 0) break;
      end
      if (t == 3000) begin
         fail("timeout");
         final_report();
      end
   endtask : drain
   initial begin
      repeat (3) @(negedge clk_in);
      rst_n_in = 1'b1;
      repeat (20) @(negedge clk_in);
      start(5'h1F, 3'b001, 8'h40, 16'h0001, 24'h0, 4'h0, 1'b0);
      start(5'h04, 3'b001, 8'h41, 16'h0000, 24'h0, 4'h0, 1'b0);
      op(3, 5'h02, 3'b001, 8'h12, 3, 24'h001800, 4'h3, 1'b0);
      start(5'h02, 3'b001, 8'h13, 16'h0001, 24'h0, 4'h0, 1'b0);
      drain();
      bic_cu_model_i.send(3, 16'h1200);
      // both units raise together: high one first, then interleave
      bic_cu_model_i.gap[1] = 60;
      bic_cu_model_i.gap[6] = 60;
      for (int u = 1; u < 7; u++) bic_cu_model_i.wait_c[u] = 20;
      op(6, 5'h05, 3'b000, 8'h66, 2, 24'h000020, 4'h0, 1'b0);
      op(1, 5'h00, 3'b000, 8'h21, 2, 24'h000010, 4'h0, 1'b0);
      bic_cu_model_i.send(4, 16'hEE00);
      for (int i = 0; i < 4; i++) begin
         logic [23:0] ra;
         ra = i[0] ? 24'h10 + 24'(i / 2) : 24'h20 + 24'(i / 2);
         exp_rd(i[0] ? 8'h21 : 8'h66, ra);
      end
      drain();
      // burst under a full fifo while a high unit waits
      bic_cu_model_i.wait_c[0] = 30;
      bic_cu_model_i.wait_c[7] = 60;
      stall = 1'b1;
      op(0, 5'h03, 3'b010, 8'h30, 20, 24'h000100, 4'h0, 1'b0);
      op(7, 5'h07, 3'b000, 8'h77, 1, 24'h000200, 4'h0, 1'b0);
      for (int i = 0; i < 20; i++) exp_rd(8'h30, 24'h000100 + i);
      exp_rd(8'h77, 24'h000200);
      repeat (300) @(negedge clk_in);
      stall = 1'b0;
      drain();
      bic_cu_model_i.wait_c[2] = 20;
      bic_cu_model_i.wait_c[5] = 20;
      op(2, 5'h09, 3'b001, 8'h19, 2, 24'h002000, 4'h5, 1'b1);
      op(5, 5'h1E, 3'b001, 8'h1A, 1, 24'h002800, 4'h0, 1'b0);
      drain();
      final_report();
   end
endmodule : test_bic_channel
